// >>> verilog/cgc_pkg.sv
package cgc_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 8;
  // register byte addresses
  localparam logic [7:0] ADDR_CTL    = 8'h00;
  localparam logic [7:0] ADDR_MULT   = 8'h04;
  localparam logic [7:0] ADDR_TRIM   = 8'h08;
  localparam logic [7:0] ADDR_DIV    = 8'h0c;
  localparam logic [7:0] ADDR_STAGE  = 8'h10;
  localparam logic [7:0] ADDR_CONFIG = 8'h14;
  // control register bit positions
  localparam int unsigned B_IRQ_EN   = 7;
  localparam int unsigned B_MFLAG    = 6;
  localparam int unsigned B_MON_EN   = 5;
  localparam int unsigned B_SEL      = 4;
  localparam int unsigned B_INT_ON   = 3;
  localparam int unsigned B_INT_STB  = 2;
  localparam int unsigned B_EXT_ON   = 1;
  localparam int unsigned B_EXT_STB  = 0;
  // reset values
  localparam logic [6:0] RST_MULT    = 7'h15;
  localparam logic [7:0] RST_TRIM    = 8'h80;
  localparam logic [3:0] RST_DIV     = 4'h0;
  localparam logic [7:0] RST_STAGE   = 8'h00;
  localparam logic       RST_SLOW    = 1'b0;
  // external startup delay in external clock cycles
  localparam logic [12:0] EXT_START_CNT = 13'h1000;
  // monitor limits, in edges of the other clock
  localparam int unsigned MON_W          = 12;
  localparam logic [11:0] LIM_INT_FAST   = 12'h100;
  localparam logic [11:0] LIM_INT_SLOW   = 12'h010;
  localparam logic [11:0] LIM_EXT_FAST   = 12'h010;
  localparam logic [11:0] LIM_EXT_SLOW   = 12'h400;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// >>> verilog/cgc_edge_watch.sv
`timescale 1ns/1ps
// counts reference edges since the last watched edge; flags loss at the limit
module cgc_edge_watch #(
  parameter int unsigned CW = 12
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          enable,
  input  wire logic          watched_edge,
  input  wire logic          ref_edge,
  input  wire logic [CW-1:0] limit,
  output logic               lost
);
  logic [CW-1:0] cnt;
  wire  [CW-1:0] cnt_inc = cnt + {{(CW-1){1'b0}}, 1'b1};

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !enable)
    begin
      cnt  <= '0;
      lost <= 1'b0;
    end
    else if (watched_edge)
    begin
      cnt  <= '0;
      lost <= 1'b0;
    end
    else if (ref_edge && !lost)
    begin
      cnt  <= cnt_inc;
      lost <= (cnt_inc >= limit);
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_WATCH_CLEARS: assert property (enable && watched_edge |=> !lost)
    else $error("loss flag stayed after a watched edge");
endmodule // cgc_edge_watch

// >>> verilog/cgc_top.sv
// Operation
// - slow option lowers amplifier drive for 30-100 kHz crystals; clear drives 1-8 MHz.
// - slow option makes monitor expect external clock slower than base clock, else faster.
// - slow-crystal option resets clear, meaning high-frequency crystal operation.
// - monitor on refuses multiplier/trim/divider/stage writes; divider/stage need internal off.
// - multiplier or trim write clears internal-stable; accepted only with monitor bits clear.
// - interrupt request is high while interrupt enable and monitor flag are both set.
// - interrupt enable sets only after monitor on a cycle; cleared when monitor off.
// - monitor flag sets when enabled monitor sees either clock go inactive.
// - flag cleared by read-while-set then write zero; cleared when monitor off.
// - monitor enable sets only with both generators on and both stable.
// - monitor enable held while flag set; cleared when either generator is off.
// - clock select one picks external clock, zero picks internal clock.
// - select sets needing external on and stable; clears needing internal on and stable.
// - select forced one on internal loss or off; zero on external loss or off.
// - internal generator may turn off only with select one and monitor off.
// - internal generator forced on while monitor on or select zero, and at reset.
// - internal-stable sets once internal generator reports frequency within about 5 percent.
// - internal-stable cleared on internal loss, generator off, multiplier write, reset.
// - external off needs select and monitor zero; forced on if either is one.
// - external-stable sets after 4096 external cycles since enable; a startup delay only.
// - external-stable cleared on external loss, generator off, and reset.
// - stop mode halts activity, holds output clock low, keeps register contents.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
module cgc_top (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [cgc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  input  wire logic [cgc_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  output logic [1:0]                      s_axi_bresp,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  input  wire logic [cgc_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  output logic [cgc_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  input  wire logic                       internal_clock,
  input  wire logic                       external_clock,
  input  wire logic                       internal_in_range,
  input  wire logic                       stop_mode,
  output logic                            osc_output_clock,
  output logic                            amp_low_drive,
  output logic                            internal_gen_enable,
  output logic                            external_gen_enable,
  output logic                            monitor_irq
);
  import cgc_pkg::*;

  // register state
  logic       monitor_irq_enable;
  logic       monitor_flag;
  logic       monitor_enable;
  logic       clock_select;
  logic       internal_gen_on;
  logic       internal_stable;
  logic       external_gen_on;
  logic       external_stable;
  logic [6:0] freq_multiplier_reg;
  logic [7:0] capacitor_trim_reg;
  logic [3:0] divide_by_two_count;
  logic [7:0] oscillator_stage_count;
  logic       slow_crystal_option;
  logic       flag_read_armed;
  logic [12:0] ext_start_cnt;

  // bus slave state
  logic                aw_held;
  logic                w_held;
  logic [ADDR_W-1:0]   aw_addr;
  logic [DATA_W-1:0]   w_data;
  logic                w_lane0;

  // sampled clock pins for edge detection
  logic int_q;
  logic ext_q;
  wire  int_edge = internal_clock & ~int_q;
  wire  ext_edge = external_clock & ~ext_q;
  wire  active   = ~stop_mode;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, ADDR_CTL) | hit(a, ADDR_MULT) | hit(a, ADDR_TRIM) |
             hit(a, ADDR_DIV) | hit(a, ADDR_STAGE) | hit(a, ADDR_CONFIG);
  endfunction
  // write decode
  wire       wr_fire   = aw_held & w_held & ~s_axi_bvalid;
  wire       wr_do     = wr_fire & w_lane0;
  wire [7:0] wd        = w_data[7:0];
  wire       ctl_wr    = wr_do & hit(aw_addr, ADDR_CTL);
  wire       mon_clear = ~monitor_irq_enable & ~monitor_flag & ~monitor_enable;
  wire       mult_wr   = wr_do & hit(aw_addr, ADDR_MULT) & mon_clear;
  wire       trim_wr   = wr_do & hit(aw_addr, ADDR_TRIM) & mon_clear;
  wire       dcoparm_ok = ~monitor_enable & ~internal_gen_on & clock_select & external_gen_on;
  wire       div_wr    = wr_do & hit(aw_addr, ADDR_DIV) & dcoparm_ok;
  wire       stage_wr  = wr_do & hit(aw_addr, ADDR_STAGE) & dcoparm_ok;
  wire       cfg_wr    = wr_do & hit(aw_addr, ADDR_CONFIG);

  // read decode
  wire       rd_fire   = s_axi_arvalid & s_axi_arready;
  wire [7:0] ctl_value = {monitor_irq_enable, monitor_flag, monitor_enable, clock_select,
                          internal_gen_on, internal_stable, external_gen_on, external_stable};
  wire [7:0] rd_byte   = hit(s_axi_araddr, ADDR_CTL)   ? ctl_value :
                         hit(s_axi_araddr, ADDR_MULT)  ? {1'b0, freq_multiplier_reg} :
                         hit(s_axi_araddr, ADDR_TRIM)  ? capacitor_trim_reg :
                         hit(s_axi_araddr, ADDR_DIV)   ? {4'h0, divide_by_two_count} :
                         hit(s_axi_araddr, ADDR_STAGE) ? oscillator_stage_count :
                         hit(s_axi_araddr, ADDR_CONFIG) ? {7'h00, slow_crystal_option} : 8'h00;

  // clock monitor: each clock is watched against edges of the other
  logic internal_lost;
  logic external_lost;
  wire  mon_run = monitor_enable & active;
  wire [MON_W-1:0] int_limit = slow_crystal_option ? LIM_INT_SLOW : LIM_INT_FAST;
  wire [MON_W-1:0] ext_limit = slow_crystal_option ? LIM_EXT_SLOW : LIM_EXT_FAST;
  cgc_edge_watch #(.CW(MON_W)) u_int_watch (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .enable       (mon_run),
    .watched_edge (int_edge),
    .ref_edge     (ext_edge),
    .limit        (int_limit),
    .lost         (internal_lost)
  );
  cgc_edge_watch #(.CW(MON_W)) u_ext_watch (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .enable       (mon_run),
    .watched_edge (ext_edge),
    .ref_edge     (int_edge),
    .limit        (ext_limit),
    .lost         (external_lost)
  );

  // control register next values; forces take priority over software
  wire all_good = internal_gen_on & external_gen_on & internal_stable & external_stable;
  wire next_monitor_enable =
    monitor_flag ? 1'b1 :
    (~internal_gen_on | ~external_gen_on) ? 1'b0 :
    ctl_wr ? (wd[B_MON_EN] ? (monitor_enable | all_good) : 1'b0) :
    monitor_enable;
  wire next_monitor_irq_enable =
    ~monitor_enable ? 1'b0 :
    ctl_wr ? (wd[B_IRQ_EN] & (monitor_irq_enable | (internal_stable & external_stable))) :
    monitor_irq_enable;
  wire flag_set = mon_run & (internal_lost | external_lost);
  wire next_monitor_flag =
    ~monitor_enable ? 1'b0 :
    flag_set ? 1'b1 :                                                 // set beats clear
    (ctl_wr & flag_read_armed & ~wd[B_MFLAG]) ? 1'b0 :
    monitor_flag;
  wire next_clock_select =
    ((mon_run & internal_lost) | ~internal_gen_on) ? 1'b1 :
    ((mon_run & external_lost) | ~external_gen_on) ? 1'b0 :
    ctl_wr ? (wd[B_SEL] ? (clock_select | (external_gen_on & external_stable))
                        : (clock_select & ~(internal_gen_on & internal_stable))) :
    clock_select;
  wire next_internal_gen_on =
    (monitor_enable | ~clock_select) ? 1'b1 :
    ctl_wr ? wd[B_INT_ON] :
    internal_gen_on;
  wire next_external_gen_on =
    (monitor_enable | clock_select) ? 1'b1 :
    ctl_wr ? wd[B_EXT_ON] :
    external_gen_on;
  wire next_internal_stable =
    ((mon_run & internal_lost) | ~internal_gen_on | mult_wr | trim_wr) ? 1'b0 :
    (active & internal_in_range) ? 1'b1 :
    internal_stable;
  wire ext_count_done = (ext_start_cnt == EXT_START_CNT);
  wire next_external_stable =
    ((mon_run & external_lost) | ~external_gen_on) ? 1'b0 :
    ext_count_done ? 1'b1 :
    external_stable;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      monitor_irq_enable <= 1'b0;
      monitor_flag       <= 1'b0;
      monitor_enable     <= 1'b0;
      clock_select       <= 1'b0;
      internal_gen_on    <= 1'b1;
      internal_stable    <= 1'b0;
      external_gen_on    <= 1'b0;
      external_stable    <= 1'b0;
      flag_read_armed    <= 1'b0;
    end
    else
    begin
      monitor_irq_enable <= next_monitor_irq_enable;
      monitor_flag       <= next_monitor_flag;
      monitor_enable     <= next_monitor_enable;
      clock_select       <= next_clock_select;
      internal_gen_on    <= next_internal_gen_on;
      internal_stable    <= next_internal_stable;
      external_gen_on    <= next_external_gen_on;
      external_stable    <= next_external_stable;
      if (rd_fire && hit(s_axi_araddr, ADDR_CTL) && monitor_flag)
        flag_read_armed <= 1'b1;
      else if (ctl_wr || !monitor_flag)
        flag_read_armed <= 1'b0;
    end
  end

  // tuning registers and configuration option
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      freq_multiplier_reg    <= RST_MULT;
      capacitor_trim_reg     <= RST_TRIM;
      divide_by_two_count    <= RST_DIV;
      oscillator_stage_count <= RST_STAGE;
      slow_crystal_option    <= RST_SLOW;
    end
    else
    begin
      if (mult_wr)
        freq_multiplier_reg <= wd[6:0];
      if (trim_wr)
        capacitor_trim_reg <= wd;
      if (div_wr)
        divide_by_two_count <= wd[3:0];
      if (stage_wr)
        oscillator_stage_count <= wd;
      if (cfg_wr)
        slow_crystal_option <= wd[0];
    end
  end

  // startup delay counts external edges from the moment the generator is on
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !external_gen_on)
      ext_start_cnt <= '0;
    else if (active && ext_edge && !ext_count_done)
      ext_start_cnt <= ext_start_cnt + 13'h0001;
  end

  // pin sampling and outputs; stop holds the output clock low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      int_q               <= 1'b0;
      ext_q               <= 1'b0;
      osc_output_clock    <= 1'b0;
      amp_low_drive       <= 1'b0;
      internal_gen_enable <= 1'b0;
      external_gen_enable <= 1'b0;
      monitor_irq         <= 1'b0;
    end
    else
    begin
      int_q               <= internal_clock;
      ext_q               <= external_clock;
      osc_output_clock    <= active & (clock_select ? external_clock : internal_clock);
      amp_low_drive       <= slow_crystal_option;
      internal_gen_enable <= internal_gen_on & active;
      external_gen_enable <= external_gen_on & active;
      monitor_irq         <= monitor_irq_enable & monitor_flag;
    end
  end

  // AXI4-Lite slave: address and data taken in either order, one write and one read at a time
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= '0;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held  <= 1'b1;
        w_data  <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_byte};
        s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_IRQ_FOLLOWS: assert property (monitor_irq_enable && monitor_flag |=> monitor_irq)
    else $error("interrupt not raised with enable and flag set");
  AST_IRQ_EN_OFF: assert property (!monitor_enable |=> !monitor_irq_enable)
    else $error("interrupt enable survived monitor off");
  AST_FLAG_OFF: assert property (!monitor_enable |=> !monitor_flag)
    else $error("monitor flag survived monitor off");
  AST_FLAG_SET: assert property (monitor_enable && flag_set |=> monitor_flag)
    else $error("clock loss did not set monitor flag");
  AST_MON_HELD: assert property (monitor_flag |=> monitor_enable)
    else $error("monitor enable dropped while flag set");
  AST_MON_SET_GATE: assert property (!monitor_enable && !all_good && !monitor_flag |=> !monitor_enable)
    else $error("monitor enable set without both clocks good");
  AST_INT_ON_FORCE: assert property (monitor_enable || !clock_select |=> internal_gen_on)
    else $error("internal generator off while forced on");
  AST_EXT_ON_FORCE: assert property (monitor_enable || clock_select |=> external_gen_on)
    else $error("external generator off while forced on");
  AST_MULT_LOCK: assert property (monitor_enable |=> $stable(freq_multiplier_reg) && $stable(capacitor_trim_reg))
    else $error("multiplier or trim changed with monitor on");
  AST_MULT_UNSTABLE: assert property (mult_wr |=> !internal_stable)
    else $error("internal stable not cleared by multiplier write");
  AST_EXT_STABLE: assert property ($rose(external_stable) |-> $past(ext_count_done))
    else $error("external stable rose before startup count");
  AST_STOP_LOW: assert property (stop_mode |=> !osc_output_clock ##0 !internal_gen_enable)
    else $error("output clock active in stop mode");
endmodule // cgc_top

// >>> sim/cgc_top_bench.sv
`timescale 1ns/1ps
module cgc_top_bench;
  import cgc_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, int_clk, ext_clk, in_range, stop;
  logic        osc_out, amp_low, int_en, ext_en, irq, int_run, ext_run;
  logic [7:0]  awaddr, araddr, v;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  integer      errors, n_tests, seed, cycles, k;

  cgc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .internal_clock(int_clk),
    .external_clock(ext_clk), .internal_in_range(in_range), .stop_mode(stop), .osc_output_clock(osc_out),
    .amp_low_drive(amp_low), .internal_gen_enable(int_en), .external_gen_enable(ext_en), .monitor_irq(irq));

  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // pin clocks toggle every 2 aclk: one rising edge every 4 aclk on each running clock
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (int_run && cycles[0])
      int_clk <= ~int_clk;
    if (ext_run && cycles[0])
      ext_clk <= ~ext_clk;
    if (cycles == 40000)
    begin
      errors = errors + 1;
      $display("[ERR] %0t run did not finish in time", $time);
      close_out;
    end
  end

  task automatic close_out;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task automatic chk8(input logic [7:0] e, input logic [7:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
        errors = errors + 1;
        $display("[ERR] %0t register exp %h got %h", $time, e, g);
      end
    end
  endtask

  task automatic chk2(input logic [1:0] e, input logic [1:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
        errors = errors + 1;
        $display("[ERR] %0t response exp %h got %h", $time, e, g);
      end
    end
  endtask

  task automatic chk1(input logic e, input logic g);
    begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
        errors = errors + 1;
        $display("[ERR] %0t pin exp %b got %b", $time, e, g);
      end
    end
  endtask

  // entered just after a rising edge; address and data are offered together
  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    begin
      ad = 1'b0;
      wd = 1'b0;
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(ad && wd))
      begin
        @(posedge aclk);
        if (awvalid && awready === 1'b1)
          ad = 1'b1;
        if (wvalid && wready === 1'b1)
          wd = 1'b1;
        awvalid <= !ad;
        wvalid <= !wd;
      end
      bready <= 1'b1;
      do
        @(posedge aclk);
      while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk2(er, bresp);
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      do
        @(posedge aclk);
      while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do
        @(posedge aclk);
      while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata[7:0];
      r = rresp;
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    begin
      axr(a, v, rs);
      chk2(RESP_OKAY, rs);
      chk8(e, v);
    end
  endtask

  task automatic wcyc(input integer n);
    repeat (n) @(posedge aclk);
  endtask

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, stop, in_range, int_clk, ext_clk, ext_run} = 11'h000;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    int_run = 1'b1;
    seed = 14888;
    errors = 0;
    n_tests = 0;
    cycles = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(ADDR_CTL, 8'h08);
    rdchk(ADDR_MULT, 8'h15);
    rdchk(ADDR_TRIM, 8'h80);
    rdchk(ADDR_CONFIG, 8'h00);
    chk1(1'b0, amp_low);
    chk1(1'b1, int_en);
    axr(8'h3c, v, rs);
    chk2(RESP_SLVERR, rs);
    chk8(8'h00, v);
    axw(8'h3c, 8'h55, RESP_SLVERR);
    in_range <= 1'b1;
    repeat (6)
    begin
      v = 8'($random(seed));
      axw(ADDR_CONFIG, v, RESP_OKAY);
      wcyc(2);
      chk1(v[0], amp_low);
      k = $random(seed);
      axw(ADDR_TRIM, k[7:0], RESP_OKAY);
      rdchk(ADDR_TRIM, k[7:0]);
      axw(ADDR_MULT, k[15:8], RESP_OKAY);
      rdchk(ADDR_MULT, {1'b0, k[14:8]});
    end
    axw(ADDR_MULT, 8'h15, RESP_OKAY);
    // a write with byte lane 0 off must leave the register alone
    wstrb <= 4'he;
    axw(ADDR_TRIM, ~k[7:0], RESP_OKAY);
    wstrb <= 4'hf;
    rdchk(ADDR_TRIM, k[7:0]);
    axw(ADDR_CONFIG, 8'h00, RESP_OKAY);
    axw(ADDR_DIV, 8'h05, RESP_OKAY);
    rdchk(ADDR_DIV, 8'h00);
    axw(ADDR_CTL, 8'h18, RESP_OKAY);
    rdchk(ADDR_CTL, 8'h0c);
    ext_run <= 1'b1;
    axw(ADDR_CTL, 8'h0a, RESP_OKAY);
    wcyc(16100);
    rdchk(ADDR_CTL, 8'h0e);
    wcyc(400);
    rdchk(ADDR_CTL, 8'h0f);
    chk1(1'b1, ext_en);
    axw(ADDR_CTL, 8'h1b, RESP_OKAY);
    rdchk(ADDR_CTL, 8'h1f);
    int_run <= 1'b0;
    k = 0;
    repeat (40) @(posedge aclk) k = k + osc_out;
    chk1(1'b1, k > 10 && k < 30);
    axw(ADDR_CTL, 8'h0b, RESP_OKAY);
    k = 0;
    repeat (40) @(posedge aclk) k = k + osc_out;
    chk1(1'b1, k == 0 || k == 40);
    int_run <= 1'b1;
    axw(ADDR_CTL, 8'h1b, RESP_OKAY);
    axw(ADDR_CTL, 8'h13, RESP_OKAY);
    rdchk(ADDR_CTL, 8'h13);
    chk1(1'b0, int_en);
    axw(ADDR_DIV, 8'h05, RESP_OKAY);
    rdchk(ADDR_DIV, 8'h05);
    axw(ADDR_CTL, 8'h1b, RESP_OKAY);
    wcyc(4);
    axw(ADDR_CTL, 8'h19, RESP_OKAY);
    rdchk(ADDR_CTL, 8'h1f);
    axw(ADDR_CTL, 8'h0f, RESP_OKAY);
    axw(ADDR_CTL, 8'h2f, RESP_OKAY);
    rdchk(ADDR_CTL, 8'h2f);
    axw(ADDR_MULT, 8'h22, RESP_OKAY);
    rdchk(ADDR_MULT, 8'h15);
    axw(ADDR_CTL, 8'haf, RESP_OKAY);
    rdchk(ADDR_CTL, 8'haf);
    // internal clock halts: loss is declared within 256 external edges
    int_run <= 1'b0;
    wcyc(1100);
    chk1(1'b1, irq);
    axw(ADDR_CTL, 8'hdb, RESP_OKAY);
    rdchk(ADDR_CTL, 8'hfb);
    int_run <= 1'b1;
    wcyc(20);
    axw(ADDR_CTL, 8'hbb, RESP_OKAY);
    rdchk(ADDR_CTL, 8'hbf);
    wcyc(2);
    chk1(1'b0, irq);
    axw(ADDR_CTL, 8'h1b, RESP_OKAY);
    rdchk(ADDR_CTL, 8'h1f);
    stop <= 1'b1;
    wcyc(3);
    chk1(1'b0, osc_out);
    chk1(1'b0, int_en);
    chk1(1'b0, ext_en);
    stop <= 1'b0;
    rdchk(ADDR_CTL, 8'h1f);
    // second reset in mid-run; range input low so the stable bit cannot set at once
    aresetn <= 1'b0;
    in_range <= 1'b0;
    wcyc(2);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk1(1'b0, irq);
    chk1(1'b0, ext_en);
    rdchk(ADDR_CTL, 8'h08);
    rdchk(ADDR_TRIM, 8'h80);
    rdchk(ADDR_DIV, 8'h00);
    close_out;
  end
endmodule // cgc_top_bench
